// ### hw/sws_top.sv
// Purpose: standby entry, wake and bus grant sequencing
// Assumes: control bits written over Avalon-MM, pins synchronised here
// Notes: clock divider output is an enable-style toggle, not a clock
`timescale 1ns/10ps
`default_nettype none
module sws_top #(
	parameter int LONG_CYC = sws_pkg::STAB_LONG_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// wake and bus pins, active low
	input wire logic nmi_n,
	input wire logic [2:0] int_n,
	input wire logic busreq_n,
	// core and clock control
	output logic osc_enable,
	output logic core_clk_run,
	output logic clk_phase,
	output logic busack_n,
	output logic halt_n,
	output logic opcode_fetch_output_n,
	output logic peripheral_halt,
	output logic irq_service,
	output logic resume_pulse
);
	// ======================================================
	// reset release
	logic [1:0] rst_sync_r;
	logic rst_n;

	// two-stage release of the async reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ======================================================
	// pin synchronisers
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	logic nmi_lo;
	logic [2:0] int_lo;
	logic breq_lo;

	// two flops on every asynchronous pin
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= 5'h1f;
			pin_s2_r <= 5'h1f;
		end else begin
			pin_s1_r <= {busreq_n, int_n, nmi_n};
			pin_s2_r <= pin_s1_r;
		end
	end
	assign nmi_lo = !pin_s2_r[0];
	assign int_lo = ~pin_s2_r[3:1];
	assign breq_lo = !pin_s2_r[4];

	// ======================================================
	// registers
	logic [31:0] ctrl_r;
	logic sleep_req_r;
	logic [2:0] int_en;
	logic [2:0] int_act;
	logic access;
	logic wr_done;

	// bytewise write helper
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return m;
	endfunction

	assign int_en = ctrl_r[sws_pkg::CTRL_INT_EN_LO +: sws_pkg::NUM_INT];
	assign int_act = int_lo & int_en;
	assign access = (avs_read || avs_write) && avs_waitrequest;
	// a write lands on the edge where the master sees waitrequest low
	assign wr_done = avs_write && !avs_waitrequest;

	// control register; reset value selects divide-by-two
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= sws_pkg::CTRL_RESET;
		end else if (wr_done && avs_address == sws_pkg::ADDR_CTRL) begin
			ctrl_r <= be_merge(ctrl_r, avs_writedata, avs_byteenable);
		end
	end

	// sleep command stands for one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_req_r <= 1'b0;
		end else begin
			sleep_req_r <= wr_done && avs_address == sws_pkg::ADDR_CMD
				&& avs_byteenable[0] && avs_writedata[sws_pkg::CMD_SLEEP];
		end
	end

	// ======================================================
	// sequencer
	sws_pkg::sws_state_t state_r;
	sws_pkg::sws_state_t state_nxt;
	sws_pkg::sws_wake_t cause_r;
	logic [2:0] wake_int_r;
	logic gie_at_wake_r;
	sws_stab_if stab_bus ();

	// stabilization counter
	sws_stab_cnt #(
		.LONG_CYC(LONG_CYC),
		.QUICK_CYC(sws_pkg::STAB_QUICK_CYC)
	) u_stab (
		.clk(sys_clk),
		.rst_n(rst_n),
		.stab(stab_bus)
	);

	// next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sws_pkg::SWS_RUN: begin
				if (sleep_req_r && ctrl_r[sws_pkg::CTRL_PERIPH_HALT] && ctrl_r[sws_pkg::CTRL_STANDBY_EN]) begin
					state_nxt = sws_pkg::SWS_STANDBY;
				end
			end
			sws_pkg::SWS_STANDBY: begin
				if (nmi_lo || |int_act) begin
					state_nxt = sws_pkg::SWS_STAB;
				end else if (breq_lo && ctrl_r[sws_pkg::CTRL_BUS_REL_EN]) begin
					state_nxt = sws_pkg::SWS_STAB;
				end
			end
			sws_pkg::SWS_STAB: begin
				if (cause_r == sws_pkg::SWS_WK_INT && !(|(int_lo & wake_int_r))) begin
					state_nxt = sws_pkg::SWS_STANDBY;
				end else if (cause_r == sws_pkg::SWS_WK_BUS && !breq_lo) begin
					state_nxt = sws_pkg::SWS_STANDBY;
				end else if (stab_bus.done) begin
					state_nxt = (cause_r == sws_pkg::SWS_WK_BUS) ? sws_pkg::SWS_GRANT
						: sws_pkg::SWS_RESUME;
				end
			end
			sws_pkg::SWS_RESUME: begin
				state_nxt = sws_pkg::SWS_RUN;
			end
			sws_pkg::SWS_GRANT: begin
				if (!breq_lo) begin
					state_nxt = sws_pkg::SWS_STANDBY;
				end
			end
			default: begin
				state_nxt = sws_pkg::SWS_RUN;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= sws_pkg::SWS_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// latch wake cause at the moment of recognition
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_r <= sws_pkg::SWS_WK_NONE;
			wake_int_r <= 3'h0;
			gie_at_wake_r <= 1'b0;
		end else if (state_r == sws_pkg::SWS_STANDBY && state_nxt == sws_pkg::SWS_STAB) begin
			gie_at_wake_r <= ctrl_r[sws_pkg::CTRL_GIE];
			wake_int_r <= int_act;
			if (nmi_lo) begin
				cause_r <= sws_pkg::SWS_WK_NMI;
			end else if (|int_act) begin
				cause_r <= sws_pkg::SWS_WK_INT;
			end else begin
				cause_r <= sws_pkg::SWS_WK_BUS;
			end
		end
	end

	// counter control: clear on entry, count while oscillator runs
	assign stab_bus.start = state_r == sws_pkg::SWS_STANDBY && state_nxt == sws_pkg::SWS_STAB;
	assign stab_bus.run = state_r == sws_pkg::SWS_STAB;
	assign stab_bus.quick = ctrl_r[sws_pkg::CTRL_QUICK_REC];

	// ======================================================
	// outputs
	logic div_tog_r;

	// clock phase: toggles in divide-by-two, held high at full rate
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_tog_r <= 1'b0;
		end else if (!ctrl_r[sws_pkg::CTRL_CLK_DIV]) begin
			div_tog_r <= !div_tog_r;
		end else begin
			div_tog_r <= 1'b1;
		end
	end

	// oscillator stops only in standby
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_enable <= 1'b1;
		end else begin
			osc_enable <= state_nxt != sws_pkg::SWS_STANDBY;
		end
	end

	// core clock released only back in run
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_clk_run <= 1'b1;
		end else begin
			core_clk_run <= state_nxt == sws_pkg::SWS_RUN;
		end
	end

	// bus acknowledge while granted
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busack_n <= 1'b1;
		end else begin
			busack_n <= state_nxt != sws_pkg::SWS_GRANT;
		end
	end

	// halt low in standby, stabilize and grant
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_n <= 1'b1;
		end else begin
			halt_n <= state_nxt == sws_pkg::SWS_RUN || state_nxt == sws_pkg::SWS_RESUME;
		end
	end

	// fetch output stays high, so halt low marks standby to outside logic
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			opcode_fetch_output_n <= 1'b1;
		end else begin
			opcode_fetch_output_n <= 1'b1;
		end
	end

	// peripheral halt mirrors the control bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_halt <= 1'b0;
		end else begin
			peripheral_halt <= ctrl_r[sws_pkg::CTRL_PERIPH_HALT];
		end
	end

	// clock phase pin copy
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_phase <= 1'b0;
		end else begin
			clk_phase <= div_tog_r;
		end
	end

	// resume pulse, one cycle after the resume state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			resume_pulse <= 1'b0;
		end else begin
			resume_pulse <= state_r == sws_pkg::SWS_RESUME;
		end
	end

	// interrupt service taken for nmi or with global enable
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_service <= 1'b0;
		end else begin
			irq_service <= state_r == sws_pkg::SWS_RESUME
				&& (cause_r == sws_pkg::SWS_WK_NMI || gie_at_wake_r);
		end
	end

	// ======================================================
	// avalon slave: one wait cycle then answer
	logic [31:0] status_w;
	assign status_w = {21'h0, state_r == sws_pkg::SWS_RUN, !busack_n, osc_enable,
		2'h0, cause_r, 1'b0, state_r};

	// waitrequest drops for one cycle per access
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !access;
			if (access && avs_read) begin
				case (avs_address)
					sws_pkg::ADDR_CTRL: begin
						avs_readdata <= ctrl_r;
					end
					sws_pkg::ADDR_STATUS: begin
						avs_readdata <= status_w;
					end
					default: begin
						avs_readdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/sws_pkg.sv
// Purpose: shared constants and types for the standby wake sequencer
// Assumes: 100 MHz sys_clk, Avalon-MM register access
// Notes: word offsets are byte addresses of aligned 32-bit registers
package sws_pkg;
	// ======================================================
	// register map (byte addresses)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CMD = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	// ======================================================
	// control register fields
	localparam int CTRL_PERIPH_HALT = 0;
	localparam int CTRL_STANDBY_EN = 1;
	localparam int CTRL_QUICK_REC = 2;
	localparam int CTRL_BUS_REL_EN = 3;
	localparam int CTRL_CLK_DIV = 4;
	localparam int CTRL_INT_EN_LO = 8;
	localparam int CTRL_GIE = 11;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// command register fields
	localparam int CMD_SLEEP = 0;
	// status register fields
	localparam int ST_STATE_LO = 0;
	localparam int ST_WAKE_LO = 4;
	localparam int ST_OSC_ON = 8;
	localparam int ST_BUS_GRANT = 9;
	localparam int ST_CORE_RUN = 10;
	// ======================================================
	// timing counts
	localparam int STAB_LONG_CYC = 131072;
	localparam int STAB_QUICK_CYC = 64;
	localparam int STAB_W = 18;
	localparam int NUM_INT = 3;
	// ======================================================
	// sequencer states, gray along run->standby->stabilize->resume
	typedef enum logic [2:0] {
		SWS_RUN = 3'b000,
		SWS_STANDBY = 3'b001,
		SWS_STAB = 3'b011,
		SWS_RESUME = 3'b010,
		SWS_GRANT = 3'b110
	} sws_state_t;
	// wake cause codes
	typedef enum logic [1:0] {
		SWS_WK_NONE = 2'h0,
		SWS_WK_NMI = 2'h1,
		SWS_WK_INT = 2'h2,
		SWS_WK_BUS = 2'h3
	} sws_wake_t;
endpackage

// ### hw/sws_stab_if.sv
// Purpose: link between sequencer and stabilization counter
// Assumes: single clock domain
// Notes: start clears the count, done is a level at terminal count
`timescale 1ns/10ps
`default_nettype none
interface sws_stab_if;
	logic start;
	logic run;
	logic quick;
	logic done;
	modport ctl (output start, output run, output quick, input done);
	modport cnt (input start, input run, input quick, output done);
endinterface
`default_nettype wire

// ### hw/sws_stab_cnt.sv
// Purpose: oscillator stabilization counter
// Assumes: counts only while run is high (oscillator restarted)
// Notes: long count is a parameter so simulation can shorten it
`timescale 1ns/10ps
`default_nettype none
module sws_stab_cnt #(
	parameter int LONG_CYC = sws_pkg::STAB_LONG_CYC,
	parameter int QUICK_CYC = sws_pkg::STAB_QUICK_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control link
	sws_stab_if.cnt stab
);
	// ======================================================
	// counter
	logic [sws_pkg::STAB_W:0] cnt_r;
	logic [sws_pkg::STAB_W:0] term;

	// terminal count picked by the quick-recovery bit
	always_comb begin
		term = stab.quick ? (sws_pkg::STAB_W+1)'(QUICK_CYC) : (sws_pkg::STAB_W+1)'(LONG_CYC);
	end

	// clear on start, count while oscillator runs, hold at terminal
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (stab.start) begin
			cnt_r <= '0;
		end else if (stab.run && cnt_r != term) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign stab.done = stab.run && !stab.start && (cnt_r == term);
endmodule
`default_nettype wire

// ### verif/sws_far_model.sv
// Purpose: far side model, interrupt sources and bus master
// Assumes: lines change just after a rising edge
// Notes: want bit0 nmi, bits3:1 int lines, bit4 bus request
`timescale 1ns/10ps
`default_nettype none
module sws_far_model (
	// clock and request pattern
	input wire logic clk,
	input wire logic [4:0] want,
	// active-low lines, idle high
	output logic nmi_n = 1'b1,
	output logic [2:0] int_n = 3'h7,
	output logic busreq_n = 1'b1
);
	// =====================================
	// master holds its request until told to drop it
	always @(posedge clk) begin
		{busreq_n, int_n, nmi_n} <= ~want;
	end
endmodule
`default_nettype wire

// ### verif/sws_top_assertions.sv
// Purpose: port-level checks of the wake sequencer
// Assumes: bench writes ctrl with all byte lanes enabled
// Notes: LONG_CYC comes through the bind
`timescale 1ns/10ps
`default_nettype none
module sws_chk #(
	parameter int LONG_CYC = 200
) (
	// clock, reset, bus
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] avs_address,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_writedata,
	// core side
	input wire logic osc_enable,
	input wire logic core_clk_run,
	input wire logic busack_n,
	input wire logic halt_n,
	input wire logic opcode_fetch_output_n,
	input wire logic irq_service,
	input wire logic resume_pulse
);
	logic [15:0] ctl_r;
	logic [17:0] osc_cnt_r;
	int need;
	// =====================================
	// shadow of ctrl low half
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			ctl_r <= 16'h0000;
		else if (avs_write && !avs_waitrequest && avs_address == sws_pkg::ADDR_CTRL)
			ctl_r <= avs_writedata[15:0];
	end
	// cycles with oscillator on and core held
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			osc_cnt_r <= 18'h00000;
		else if (!osc_enable || core_clk_run)
			osc_cnt_r <= 18'h00000;
		else
			osc_cnt_r <= osc_cnt_r + 18'h00001;
	end
	assign need = ctl_r[2] ? 64 : LONG_CYC;
	// =====================================
	// assertions
	fetch_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn) opcode_fetch_output_n)
		else $error("fetch output low");
	osc_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn) $fell(osc_enable) |-> ctl_r[1:0] == 2'b11)
		else $error("oscillator stopped without standby bits");
	standby_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) !osc_enable |-> !halt_n && !core_clk_run)
		else $error("core active while oscillator off");
	grant_enable_a: assert property (@(posedge sys_clk) disable iff (!rstn) $fell(busack_n) |-> ctl_r[3])
		else $error("bus granted without release enable");
	stab_min_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		resume_pulse || $fell(busack_n) |-> int'(osc_cnt_r) >= need)
		else $error("wake before stabilization count");
	stab_max_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		resume_pulse || $fell(busack_n) |-> int'(osc_cnt_r) <= need + 8)
		else $error("wake long after stabilization count");
	irq_pair_a: assert property (@(posedge sys_clk) disable iff (!rstn) irq_service |-> resume_pulse)
		else $error("service without resume");
	irq_gie_a: assert property (@(posedge sys_clk) disable iff (!rstn) resume_pulse && ctl_r[11] |-> irq_service)
		else $error("service skipped with global enable");
	osc_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn) $rose(osc_enable) |-> !resume_pulse [*8])
		else $error("resume right after oscillator start");
endmodule
bind sws_top sws_chk #(.LONG_CYC(LONG_CYC)) u_chk (.sys_clk, .rstn, .avs_address, .avs_write, .avs_waitrequest,
	.avs_writedata, .osc_enable, .core_clk_run, .busack_n, .halt_n, .opcode_fetch_output_n, .irq_service, .resume_pulse);
`default_nettype wire

// ### verif/testbench.sv
// Purpose: self-checking bench for the wake sequencer
// Assumes: LONG_CYC shortened to 200
// Notes: driver queues expectations, watcher pops them
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
	localparam int LONG = 200;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, ctl;
	logic [2:0] int_n;
	logic [4:0] want = 5'h00;
	logic [4:0] want_v;
	logic avs_waitrequest, nmi_n, busreq_n, osc_enable, core_clk_run, clk_phase, busack_n, halt_n;
	logic peripheral_halt, irq_service, resume_pulse, ph, gie, qk;
	logic [31:0] exp_q[$];
	int err_total = 0;
	int total_checks = 0;
	int k, ln;
	// =====================================
	initial forever #5 sys_clk = ~sys_clk;
	sws_top #(.LONG_CYC(LONG)) u_dut (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .nmi_n, .int_n, .busreq_n, .osc_enable,
		.core_clk_run, .clk_phase, .busack_n, .halt_n, .opcode_fetch_output_n(), .peripheral_halt,
		.irq_service, .resume_pulse);
	sws_far_model u_far (.clk(sys_clk), .want, .nmi_n, .int_n, .busreq_n);
	// result watcher
	always @(posedge sys_clk) begin
		logic [31:0] got;
		got = (avs_read && avs_waitrequest === 1'b0) ? avs_readdata : resume_pulse ? 32'h100 | irq_service : 32'h200;
		if (rstn && ((avs_read && avs_waitrequest === 1'b0) || resume_pulse === 1'b1 || $fell(busack_n))) begin
			if (exp_q.size() == 0)
				`CHK(got, 32'hffff_ffff)
			else
				`CHK(got, exp_q.pop_front())
		end
	end
	// =====================================
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic fail_wait();
		err_total++;
		$display("[ERR] %0t got %h exp %h", $time, 32'h0, 32'h1);
		stop_test();
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (n == 20) fail_wait();
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic drain();
		int n;
		for (n = 0; n < 800 && exp_q.size() != 0; n++) @(posedge sys_clk);
		if (exp_q.size() != 0) fail_wait();
	endtask
	task automatic wait_osc(input logic v);
		int n;
		for (n = 0; n < 50 && osc_enable !== v; n++) @(posedge sys_clk);
		if (n == 50) fail_wait();
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask
	// =====================================
	// main sequence
	initial begin
		void'($urandom(15006));
		do_reset();
		rd(sws_pkg::ADDR_CTRL, sws_pkg::CTRL_RESET);
		rd(4'hc, 32'h0);
		rd(sws_pkg::ADDR_CMD, 32'h0);
		@(posedge sys_clk);
		ph = clk_phase;
		@(posedge sys_clk);
		`CHK(clk_phase, ~ph)
		bus(1'b1, sws_pkg::ADDR_CTRL, 32'h10);
		repeat (4) @(posedge sys_clk);
		`CHK(clk_phase, 1'b1)
		// int wakes on random lines, then nmi, then bus grant
		for (k = 0; k < 7; k++) begin
			ln = $urandom % 3;
			gie = 1'($urandom % 2);
			qk = (k < 2) ? k[0] : 1'($urandom % 2);
			ctl = 32'h3 | ({31'h0, qk} << 2) | (32'h100 << ln) | ({31'h0, gie} << 11) | ((k == 6) ? 32'h8 : 32'h0);
			want_v = (k == 5) ? 5'h01 : (k == 6) ? 5'h10 : (5'h02 << ln);
			bus(1'b1, sws_pkg::ADDR_CTRL, ctl);
			bus(1'b1, sws_pkg::ADDR_CMD, 32'h1);
			wait_osc(1'b0);
			`CHK(halt_n, 1'b0)
			exp_q.push_back(k == 6 ? 32'h200 : k == 5 ? 32'h101 : 32'h100 | gie);
			want <= want_v;
			drain();
			want <= 5'h00;
		end
		wait_osc(1'b0);
		`CHK(busack_n, 1'b1)
		`CHK(peripheral_halt, 1'b1)
		// short int pulse, then a disabled line, then refused bus
		bus(1'b1, sws_pkg::ADDR_CTRL, 32'h10b);
		want <= 5'h02;
		repeat (30) @(posedge sys_clk);
		want <= 5'h04;
		repeat (300) @(posedge sys_clk);
		`CHK(osc_enable, 1'b0)
		bus(1'b1, sws_pkg::ADDR_CTRL, 32'h103);
		want <= 5'h10;
		repeat (300) @(posedge sys_clk);
		`CHK(busack_n, 1'b1)
		exp_q.push_back(32'h200);
		bus(1'b1, sws_pkg::ADDR_CTRL, 32'h10f);
		drain();
		want <= 5'h00;
		wait_osc(1'b0);
		do_reset();
		`CHK(core_clk_run, 1'b1)
		`CHK(peripheral_halt, 1'b0)
		rd(sws_pkg::ADDR_CTRL, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
